// file: pkg/fars_pkg.sv
// constants and state encoding for the fault auto-restart sequencer
// assumes one 20 mhz system clock and seconds-resolution settings
package fars_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned SEC_NS      = 1000000000;
  localparam int unsigned CLK_NS      = SEC_NS / CLK_HZ;
  localparam int unsigned TICK_SEC    = 1;
  localparam int unsigned TICK_CYCLES = TICK_SEC * (SEC_NS / CLK_NS);

  // ----------------------------------------------------------------
  // setting widths, ranges and defaults
  // ----------------------------------------------------------------
  localparam int SECS_W = 13;
  localparam int ATT_W  = 4;
  localparam int OUT_W  = SECS_W + ATT_W;
  localparam logic [SECS_W-1:0] DELAY_MAX     = 13'h1c20;
  localparam logic [SECS_W-1:0] DELAY_DEF     = 13'h0000;
  localparam logic [ATT_W-1:0]  ATT_MAX       = 4'ha;
  localparam logic [ATT_W-1:0]  ATT_DEF       = 4'h0;
  localparam logic [SECS_W-1:0] TFREE_MIN     = 13'h0078;
  localparam logic [SECS_W-1:0] TFREE_MAX     = 13'h1c20;
  localparam logic [SECS_W-1:0] TFREE_DEF     = 13'h0258;
  localparam logic              RESTART_EN_DEF = 1'b0;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_DELAY = 4'h2,
    ST_RUN   = 4'h4,
    ST_DONE  = 4'h8
  } fars_state_type;
endpackage

// file: rtl/fars_tick.sv
// one-second tick generator for the restart timers
// assumes a free-running system clock; period set by the top
`timescale 1ns/1ps
module fars_tick #(
  parameter int unsigned TICK_CYCLES = 20000000
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);
  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  // count up to the last cycle, then pulse for one cycle
  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 32'h1;
    if (cnt_q >= TICK_CYCLES - 1) begin
      cnt_d  = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule

// file: rtl/fars_top.sv
// fault auto-restart sequencer: retries a tripped starter after a delay
// assumes trip, power-up and outage inputs come from logic on i_sys_clk;
// start, stop and reset inputs are pins and are synchronised here
`timescale 1ns/1ps
module fars_top
  import fars_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_restart_en,
  input  wire logic [SECS_W-1:0] i_reset_delay,
  input  wire logic [ATT_W-1:0]  i_attempt_limit,
  input  wire logic [SECS_W-1:0] i_trip_free,
  input  wire logic              i_hand_sel,
  input  wire logic              i_two_wire,
  input  wire logic              i_start,
  input  wire logic              i_stop,
  input  wire logic              i_reset_in,
  input  wire logic              i_trip,
  input  wire logic              i_power_up,
  input  wire logic [OUT_W-1:0]  i_outage_secs,
  input  wire logic              i_saved_start,
  output logic                   o_clear_trip,
  output logic                   o_restart,
  output logic                   o_pending,
  output logic                   o_exceeded,
  output logic [ATT_W-1:0]       o_attempts_left,
  output logic [SECS_W-1:0]      o_delay_left,
  output logic [SECS_W-1:0]      o_tfree_left
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       start_prev_q;
  logic [2:0] armed_q;

  // first stage is read only by the second stage
  // armed_q fills once the stages hold a real pin level, so a start
  // held across reset is not mistaken for a rising edge
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q       <= 3'h0;
      sync_q       <= 3'h0;
      start_prev_q <= 1'b0;
      armed_q      <= 3'h0;
    end else begin
      meta_q       <= {i_reset_in, i_stop, i_start};
      sync_q       <= meta_q;
      start_prev_q <= sync_q[0];
      armed_q      <= {armed_q[1:0], 1'b1};
    end
  end

  logic start_s;
  logic stop_s;
  logic reset_s;
  logic start_rise;
  logic start_fall;
  assign start_s    = sync_q[0];
  assign stop_s     = sync_q[1];
  assign reset_s    = sync_q[2];
  assign start_rise = start_s & ~start_prev_q & armed_q[2];
  assign start_fall = ~start_s & start_prev_q & armed_q[2];

  // ----------------------------------------------------------------
  // settings clamped into range
  // ----------------------------------------------------------------
  // clamping keeps an out-of-range setting from stalling a timer
  function automatic logic [SECS_W-1:0] clamp_s(input logic [SECS_W-1:0] v,
                                                input logic [SECS_W-1:0] lo,
                                                input logic [SECS_W-1:0] hi);
    clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic [SECS_W-1:0] delay_set;
  logic [SECS_W-1:0] tfree_set;
  logic [ATT_W-1:0]  att_set;
  logic [OUT_W-1:0]  outage_limit;
  assign delay_set = clamp_s(i_reset_delay, DELAY_DEF, DELAY_MAX);
  assign tfree_set = clamp_s(i_trip_free, TFREE_MIN, TFREE_MAX);
  assign att_set   = (i_attempt_limit > ATT_MAX) ? ATT_MAX : i_attempt_limit;
  assign outage_limit = OUT_W'(delay_set) * OUT_W'(att_set);

  // ----------------------------------------------------------------
  // seconds tick
  // ----------------------------------------------------------------
  logic tick;
  fars_tick #(
    .TICK_CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .o_tick    (tick)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  fars_state_type    state_q;
  fars_state_type    state_d;
  logic [ATT_W-1:0]  att_q;
  logic [ATT_W-1:0]  att_d;
  logic [SECS_W-1:0] dly_q;
  logic [SECS_W-1:0] dly_d;
  logic [SECS_W-1:0] tf_q;
  logic [SECS_W-1:0] tf_d;
  logic              clr_q;
  logic              clr_d;
  logic              rst_q;
  logic              rst_d;

  logic user_reset;
  logic stop_3w;
  logic active;
  assign user_reset = reset_s | (i_two_wire & start_rise);
  assign stop_3w    = ~i_two_wire & stop_s;
  assign active     = (state_q == ST_DELAY) | (state_q == ST_RUN);

  // priority: hand, then terminations, then user reset, then sequence
  always_comb begin
    state_d = state_q;
    att_d   = att_q;
    dly_d   = dly_q;
    tf_d    = tf_q;
    clr_d   = 1'b0;
    rst_d   = 1'b0;
    if (user_reset) begin
      clr_d = 1'b1;
    end
    if (!i_restart_en || i_hand_sel) begin
      state_d = ST_IDLE;
      att_d   = att_set;
      dly_d   = delay_set;
      tf_d    = tfree_set;
    end else if (active && i_two_wire && start_fall) begin
      state_d = ST_IDLE;
      att_d   = att_set;
      dly_d   = delay_set;
      tf_d    = tfree_set;
    end else if ((active || state_q == ST_DONE) && stop_3w) begin
      state_d = ST_IDLE;
      att_d   = att_set;
      dly_d   = delay_set;
      tf_d    = tfree_set;
    end else if (state_q != ST_IDLE && user_reset) begin
      // user reset reinitialises, releases exceeded hold
      state_d = ST_IDLE;
      att_d   = att_set;
      dly_d   = delay_set;
      tf_d    = tfree_set;
    end else if (active && i_power_up) begin
      if (i_outage_secs > outage_limit) begin
        // outage too long, terminate and hold
        state_d = ST_DONE;
      end else if (!i_two_wire && !i_saved_start) begin
        // no saved start, do not resume
        state_d = ST_IDLE;
        att_d   = att_set;
        dly_d   = delay_set;
        tf_d    = tfree_set;
      end else if (state_q == ST_DELAY) begin
        if (OUT_W'(dly_q) > i_outage_secs) begin
          dly_d = dly_q - i_outage_secs[SECS_W-1:0];
        end else begin
          dly_d = '0;
        end
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          att_d = att_set;
          dly_d = delay_set;
          tf_d  = tfree_set;
          if (i_trip) begin
            state_d = (att_set != 4'h0) ? ST_DELAY : ST_DONE;
          end
        end
        ST_DELAY: begin
          if (dly_q == 13'h0000) begin
            clr_d   = 1'b1;
            rst_d   = 1'b1;
            att_d   = att_q - 4'h1;
            tf_d    = tfree_set;
            state_d = ST_RUN;
          end else if (tick) begin
            dly_d = dly_q - 13'h0001;
          end
        end
        ST_RUN: begin
          if (i_trip) begin
            dly_d   = delay_set;
            state_d = (att_q != 4'h0) ? ST_DELAY : ST_DONE;
          end else if (tf_q == 13'h0000) begin
            att_d   = att_set;
            state_d = ST_IDLE;
          end else if (tick) begin
            tf_d = tf_q - 13'h0001;
          end
        end
        ST_DONE: begin
          state_d = ST_DONE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      att_q   <= ATT_DEF;
      dly_q   <= DELAY_DEF;
      tf_q    <= TFREE_DEF;
      clr_q   <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      att_q   <= att_d;
      dly_q   <= dly_d;
      tf_q    <= tf_d;
      clr_q   <= clr_d;
      rst_q   <= rst_d;
    end
  end

  // ----------------------------------------------------------------
  // status outputs, all registered
  // ----------------------------------------------------------------
  logic pend_q;
  logic exc_q;
  logic pend_d;
  logic exc_d;
  always_comb begin
    pend_d = (state_d == ST_DELAY);
    exc_d  = (state_d == ST_DONE);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 1'b0;
      exc_q  <= 1'b0;
    end else begin
      pend_q <= pend_d;
      exc_q  <= exc_d;
    end
  end

  assign o_clear_trip    = clr_q;
  assign o_restart       = rst_q;
  assign o_pending       = pend_q;
  assign o_exceeded      = exc_q;
  assign o_attempts_left = att_q;
  assign o_delay_left    = dly_q;
  assign o_tfree_left    = tf_q;
endmodule

// file: sim/fars_partner.sv
// trip source standing on the sequencer's far side
// assumes bench commands on falling edges; samples them on rising edges
`timescale 1ns/1ps
module fars_partner (
  input  wire logic i_sys_clk,
  input  wire logic i_fault,
  input  wire logic i_drop,
  input  wire logic i_retrip,
  input  wire logic i_clear_trip,
  input  wire logic i_restart,
  output logic      o_trip
);
  int   cnt_q  = 0;
  logic trip_q = 1'b0;
  // trip holds until cleared or dropped; a hot load trips again shortly after
  // retrip after restart
  always @(posedge i_sys_clk) begin
    cnt_q <= (i_restart && i_retrip) ? 3 : ((cnt_q > 0) ? cnt_q - 1 : 0);
    if (i_fault || cnt_q == 1)
      trip_q <= 1'b1;
    else if (i_clear_trip || i_drop)
      trip_q <= 1'b0;
  end
  // the clear pulse drops the trip at once, before the next sampling edge
  assign o_trip = trip_q & ~i_clear_trip;
endmodule

// file: sim/fars_top_properties.sv
// port-level checks on the fault auto-restart sequencer
// assumes one clock domain; bound onto every fars_top instance
`timescale 1ns/1ps
module fars_top_properties
  import fars_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  input wire logic              i_restart_en,
  input wire logic [SECS_W-1:0] i_reset_delay,
  input wire logic [ATT_W-1:0]  i_attempt_limit,
  input wire logic [SECS_W-1:0] i_trip_free,
  input wire logic              i_hand_sel,
  input wire logic              i_two_wire,
  input wire logic              i_start,
  input wire logic              i_stop,
  input wire logic              i_reset_in,
  input wire logic              i_trip,
  input wire logic              i_power_up,
  input wire logic [OUT_W-1:0]  i_outage_secs,
  input wire logic              i_saved_start,
  input wire logic              o_clear_trip,
  input wire logic              o_restart,
  input wire logic              o_pending,
  input wire logic              o_exceeded,
  input wire logic [ATT_W-1:0]  o_attempts_left,
  input wire logic [SECS_W-1:0] o_delay_left,
  input wire logic [SECS_W-1:0] o_tfree_left
);
  // settings after clamping, as the sequencer applies them
  logic [ATT_W-1:0]  lim_c;
  logic [SECS_W-1:0] dly_c;
  logic [OUT_W-1:0]  prod_c;
  assign lim_c  = (i_attempt_limit > ATT_MAX) ? ATT_MAX : i_attempt_limit;
  assign dly_c  = (i_reset_delay > DELAY_MAX) ? DELAY_MAX : i_reset_delay;
  assign prod_c = OUT_W'(dly_c) * OUT_W'(lim_c);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // two cycles of hand, so a reload one edge late still passes
  AST_HAND_ABORT: assert property (i_hand_sel [*2] |=>
    !o_pending && !o_exceeded && o_attempts_left == $past(lim_c))
    else $error("hand override left the sequence running");
  AST_RESTART_CLEARS: assert property (o_restart |-> o_clear_trip)
    else $error("restart issued without clearing the trip");
  AST_RESTART_DEC: assert property (
    o_restart |-> o_attempts_left == $past(o_attempts_left) - 4'h1)
    else $error("restart did not take one attempt");
  AST_PEND_FIRST: assert property (o_restart |-> $past(o_pending))
    else $error("restart without a pending delay before it");
  AST_EXC_QUIET: assert property (o_exceeded |-> !o_pending && !o_restart)
    else $error("activity while attempts are exhausted");
  // pins pass a two-stage synchroniser, hence four cycles held
  AST_STOP_ENDS: assert property (
    (!i_two_wire && i_stop && !i_trip) [*4] |=> !o_pending && !o_exceeded)
    else $error("stop did not end the sequence");
  AST_WITHDRAW: assert property ((i_two_wire && !i_start && !i_trip) [*4] |=> !o_pending)
    else $error("start withdrawal did not end the sequence");
  AST_OUTAGE_END: assert property (i_power_up && o_pending && i_restart_en
    && !i_hand_sel && i_outage_secs > prod_c |=> o_exceeded)
    else $error("overlong outage did not terminate");

  COV_RESTART: cover property (o_restart);
  COV_EXCEEDED: cover property ($rose(o_exceeded));
  COV_POWER: cover property (i_power_up && o_pending);
endmodule

bind fars_top fars_top_properties #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_fars_top_properties (
  .i_sys_clk, .i_rst_n, .i_restart_en, .i_reset_delay, .i_attempt_limit, .i_trip_free,
  .i_hand_sel, .i_two_wire, .i_start, .i_stop, .i_reset_in, .i_trip, .i_power_up,
  .i_outage_secs, .i_saved_start, .o_clear_trip, .o_restart, .o_pending, .o_exceeded,
  .o_attempts_left, .o_delay_left, .o_tfree_left);

// file: sim/testbench.sv
// self-checking bench for the fault auto-restart sequencer
// assumes the trip model in fars_partner; one-second tick cut to 10 cycles
`timescale 1ns/1ps
module testbench;
  import fars_pkg::*;
  localparam int unsigned TK = 10;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, hand = 1'b0, two = 1'b1, start = 1'b1;
  logic stop = 1'b0, rin = 1'b0, pwr = 1'b0, fault = 1'b0, drop = 1'b0, retrip = 1'b0;
  logic [SECS_W-1:0] dly = 13'h0000, tf = 13'h0005;
  logic [ATT_W-1:0]  lim = 4'h2;
  logic [OUT_W-1:0]  outg = 17'h00000;
  logic              trip, clr, rst_o, pend, exc;
  logic              sav = 1'b1;
  logic [ATT_W-1:0]  att;
  logic [SECS_W-1:0] dleft, tleft;
  int                n_fail = 0, compares = 0, n_rst = 0;

  always #25 clk = ~clk;
  // restart pulses counted for the retry test
  always @(posedge clk) if (rst_o === 1'b1) n_rst <= n_rst + 1;

  fars_top #(.TICK_CYCLES_P(TK)) i_fars_top (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_restart_en(en), .i_reset_delay(dly),
    .i_attempt_limit(lim), .i_trip_free(tf), .i_hand_sel(hand), .i_two_wire(two),
    .i_start(start), .i_stop(stop), .i_reset_in(rin), .i_trip(trip), .i_power_up(pwr),
    .i_outage_secs(outg), .i_saved_start(sav), .o_clear_trip(clr), .o_restart(rst_o),
    .o_pending(pend), .o_exceeded(exc), .o_attempts_left(att), .o_delay_left(dleft),
    .o_tfree_left(tleft));
  fars_partner i_fars_partner (.i_sys_clk(clk), .i_fault(fault), .i_drop(drop),
    .i_retrip(retrip), .i_clear_trip(clr), .i_restart(rst_o), .o_trip(trip));

  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle pulse, raised and lowered on falling edges
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // bounded wait, so a stuck sequencer cannot hang the run
  task automatic wait_hi(ref logic s, input int n);
    for (int k = 0; k < n && s !== 1'b1; k++) cyc(1);
  endtask
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog, well beyond the roughly 1400 cycles the tests need
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end

  initial begin
    cyc(20);
    chk("tfree_rst", OUT_W'(TFREE_DEF), OUT_W'(tleft));
    chk("att_rst", OUT_W'(ATT_DEF), OUT_W'(att));
    rst_n = 1'b1;
    // test 1: trip, restart, counters restored after the quiet time
    pulse(fault);
    wait_hi(rst_o, 50);
    chk("restart", 17'h1, OUT_W'(rst_o));
    chk("clear", 17'h1, OUT_W'(clr));
    chk("att_dec", 17'h1, OUT_W'(att));
    chk("tfree_clamp", 17'h78, OUT_W'(tleft));
    cyc(600);
    chk("att_early", 17'h1, OUT_W'(att));
    for (int k = 0; k < 1400 && att !== 4'h2; k++) cyc(1);
    chk("att_restore", 17'h2, OUT_W'(att));
    $display("test 1 done");
    // test 2: hot load retrips until attempts run out, then stop
    two = 1'b0;
    retrip = 1'b1;
    dly = 13'h0001;
    n_rst = 0;
    pulse(fault);
    wait_hi(exc, 400);
    chk("exceeded", 17'h1, OUT_W'(exc));
    chk("n_restart", 17'h2, OUT_W'(n_rst));
    cyc(30);
    chk("held", 17'h10, OUT_W'({exc, att}));
    retrip = 1'b0;
    pulse(drop);
    stop = 1'b1;
    cyc(6);
    stop = 1'b0;
    chk("stop_reinit", 17'h02, OUT_W'({exc, att}));
    $display("test 2 done");
    // test 3: hand, start withdrawal, stop and restart disable each abandon the delay
    dly = 13'h0003;
    for (int m = 0; m < 4; m++) begin
      two = (m == 1);
      pulse(fault);
      wait_hi(pend, 20);
      pulse(drop);
      hand = (m == 0);
      en = (m != 3);
      start = (m != 1);
      stop = (m == 2);
      cyc(6);
      chk("abort_pend", 17'h0, OUT_W'(pend));
      chk("abort_att", 17'h2, OUT_W'(att));
      hand = 1'b0;
      en = 1'b1;
      start = 1'b1;
      stop = 1'b0;
      if (m == 1) wait_hi(clr, 6);
      if (m == 1) chk("rise_clear", 17'h1, OUT_W'(clr));
      cyc(4);
    end
    $display("test 3 done");
    // test 4: outages, too long then short, with a user reset between
    pulse(fault);
    wait_hi(pend, 20);
    outg = 17'h00007;
    pulse(pwr);
    chk("outage_end", 17'h1, OUT_W'(exc));
    pulse(rin);
    cyc(5);
    chk("user_reset", 17'h02, OUT_W'({exc, att}));
    pulse(fault);
    wait_hi(pend, 20);
    outg = 17'h00002;
    pulse(pwr);
    chk("resume", 17'h1, OUT_W'(pend && !exc && dleft <= 13'h0001));
    // hand ends the resumed delay; the standing trip starts a new one
    hand = 1'b1;
    cyc(2);
    hand = 1'b0;
    wait_hi(pend, 20);
    pulse(drop);
    sav = 1'b0;
    pulse(pwr);
    chk("no_saved", 17'h02, OUT_W'({pend, exc, att}));
    $display("test 4 done");
    conclude();
  end
endmodule
